/* design/upcc_pkg.sv */
// Contract
// RULE_01: Config fields act on the window-selected pipe; select zero reads zero, ignores writes.
// RULE_02: Transfer kind 00 unused, 01 bulk, 10 interrupt, 11 isochronous.
// RULE_03: Software programs pipes 1-2 bulk/iso, 3-5 bulk, 6-9 interrupt only.
// RULE_04: Accept-data mode needs non-zero kind; traffic starts only once accept-data is written.
// RULE_05: Software changes transfer kind only while the pipe response mode is NAK.
// RULE_06: After leaving accept-data, software waits for split and active flags at zero.
// RULE_07: Ready-on-read option works only on pipes 1 to 5.
// RULE_08: Ready-on-read receive pipe raises ready event once the packet is fully read.
// RULE_09: Ready-on-read receive FIFO stays held until the clear command is written.
// RULE_10: Ready-on-read transmit pipe never raises the ready event.
// RULE_11: Software changes timing, double and continuous bits only when idle and NAK.
// RULE_12: Software flushes a used FIFO with auto flush one then zero first.
// RULE_13: Pipes 1-5 get (block count+1)*64*(double+1) bytes of FIFO.
// RULE_14: Double-side transmit pipe never raises the ready event.
// RULE_15: Continuous mode applies only to bulk pipes 1 to 5.
// RULE_16: Non-continuous receive: FIFO readable after one packet.
// RULE_17: Non-continuous transmit: sendable on max-size packet, or short packet with commit.
// RULE_18: Continuous receive: readable when byte count equals one side size.
// RULE_19: Continuous receive: readable on non-zero short packet, or zero packet with data held.
// RULE_20: Continuous receive: readable when received packets reach the transaction counter.
// RULE_21: Continuous transmit: short side sendable with commit flag or last-write strobe.
// RULE_22: Continuous transmit: sendable when written data exactly fills one side.
`default_nettype none
package upcc_pkg;
  localparam logic [7:0] ADDR_SEL = 8'h64;
  localparam logic [7:0] ADDR_CFG = 8'h68;
  localparam logic [7:0] ADDR_ALLOC = 8'h6C;
  localparam logic [7:0] ADDR_MAXP = 8'h70;
  localparam logic [7:0] ADDR_CTRL = 8'h74;
  localparam logic [7:0] ADDR_STAT = 8'h78;
  localparam logic [7:0] ADDR_SIZE = 8'h7C;
  localparam int CFG_KIND_POS = 14;
  localparam int CFG_ROR_POS = 10;
  localparam int CFG_DBL_POS = 9;
  localparam int CFG_CONT_POS = 8;
  localparam int CFG_DIR_POS = 4;
  localparam int ALLOC_BC_POS = 10;
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_FLUSH_POS = 1;
  localparam int CTRL_CLR_POS = 2;
  localparam int CTRL_TXN_POS = 8;
  localparam int STAT_CNT_POS = 4;
  localparam int NPIPE = 9;
  localparam logic [3:0] LAST_BUF_PIPE = 4'h5;
  localparam logic [12:0] BLOCK_BYTES = 13'h0040;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [10:0] MAXP_RESET = 11'h040;
  typedef enum logic [1:0] {
    UPCC_KIND_NONE = 2'b00,
    UPCC_KIND_BULK = 2'b01,
    UPCC_KIND_INTR = 2'b10,
    UPCC_KIND_ISO = 2'b11
  } upcc_kind_t;
  typedef struct packed {
    upcc_kind_t kind;
    logic ready_on_read_option;
    logic double_side_fifo;
    logic continuous_mode;
    logic dir;
    logic [4:0] fifo_block_count;
    logic [10:0] max_pkt;
    logic [7:0] txn_target;
    logic accept;
  } upcc_cfg_t;
  typedef struct packed {
    logic valid;
    logic [3:0] pipe;
    logic [10:0] bytes;
  } upcc_pkt_t;
endpackage : upcc_pkg
`default_nettype wire

/* design/upcc_pipe_config.sv */
`default_nettype none
module upcc_pipe_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire upcc_pkg::upcc_pkt_t rx_pkt,
  input wire upcc_pkg::upcc_pkt_t tx_sent,
  input wire upcc_pkg::upcc_pkt_t cpu_wr,
  input wire logic cpu_commit,
  input wire logic dma_last_write_n,
  input wire upcc_pkg::upcc_pkt_t cpu_rd_done,
  output logic [9:0] traffic_enable,
  output logic [9:0] fifo_readable,
  output logic [9:0] fifo_sendable,
  output logic [9:0] fifo_ready_event
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [12:0] side_bytes(input upcc_pkg::upcc_cfg_t c);
    side_bytes = 13'((c.fifo_block_count + 6'h01) * upcc_pkg::BLOCK_BYTES);
  endfunction : side_bytes

  function automatic logic buf_pipe(input logic [3:0] p);
    buf_pipe = (p != 4'h0) && (p <= upcc_pkg::LAST_BUF_PIPE);
  endfunction : buf_pipe

  function automatic logic cont_on(input upcc_pkg::upcc_cfg_t c, input logic [3:0] p);
    cont_on = c.continuous_mode && buf_pipe(p) && (c.kind == upcc_pkg::UPCC_KIND_BULK); // RULE_15
  endfunction : cont_on

  function automatic logic pkt_for(input upcc_pkg::upcc_pkt_t k, input logic [3:0] p);
    pkt_for = k.valid && (k.pipe == p);
  endfunction : pkt_for

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [3:0] sel_reg;
  upcc_pkg::upcc_cfg_t cfg_reg [1:upcc_pkg::NPIPE];
  logic flush_reg [1:upcc_pkg::NPIPE];
  logic [12:0] cnt_reg [1:upcc_pkg::NPIPE];
  logic [7:0] pkts_reg [1:upcc_pkg::NPIPE];
  logic [9:0] readable_reg;
  logic [9:0] sendable_reg;
  logic [9:0] hold_reg;
  logic [9:0] event_reg;
  logic acc_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic wr_take;
  logic rd_take;
  logic hit;
  upcc_pkg::upcc_cfg_t cur;
  logic [31:0] rd_next;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_comb
  begin
    hit = (paddr == upcc_pkg::ADDR_SEL) || (paddr == upcc_pkg::ADDR_CFG) || (paddr == upcc_pkg::ADDR_ALLOC) ||
          (paddr == upcc_pkg::ADDR_MAXP) || (paddr == upcc_pkg::ADDR_CTRL) || (paddr == upcc_pkg::ADDR_STAT) ||
          (paddr == upcc_pkg::ADDR_SIZE);
  end

  assign rd_take = psel && penable && !acc_reg;
  assign wr_take = psel && penable && acc_reg && pwrite && hit;
  assign pready = acc_reg;
  assign prdata = rdata_reg;
  assign pslverr = err_reg && acc_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_reg <= 1'b0;
    else
      acc_reg <= rd_take;
  end

  always_comb
  begin
    cur = (sel_reg == 4'h0) ? '0 : cfg_reg[sel_reg]; // RULE_01
    rd_next = 32'h0000_0000;
    if (paddr == upcc_pkg::ADDR_SEL)
      rd_next[3:0] = sel_reg;
    else if (sel_reg == 4'h0)
      rd_next = 32'h0000_0000; // RULE_01
    else if (paddr == upcc_pkg::ADDR_CFG)
    begin
      rd_next[upcc_pkg::CFG_KIND_POS +: 2] = cur.kind;
      rd_next[upcc_pkg::CFG_ROR_POS] = cur.ready_on_read_option;
      rd_next[upcc_pkg::CFG_DBL_POS] = cur.double_side_fifo;
      rd_next[upcc_pkg::CFG_CONT_POS] = cur.continuous_mode;
      rd_next[upcc_pkg::CFG_DIR_POS] = cur.dir;
    end
    else if (paddr == upcc_pkg::ADDR_ALLOC)
      rd_next[upcc_pkg::ALLOC_BC_POS +: 5] = cur.fifo_block_count;
    else if (paddr == upcc_pkg::ADDR_MAXP)
      rd_next[10:0] = cur.max_pkt;
    else if (paddr == upcc_pkg::ADDR_CTRL)
    begin
      rd_next[upcc_pkg::CTRL_MODE_POS] = cur.accept;
      rd_next[upcc_pkg::CTRL_FLUSH_POS] = flush_reg[sel_reg];
      rd_next[upcc_pkg::CTRL_TXN_POS +: 8] = cur.txn_target;
    end
    else if (paddr == upcc_pkg::ADDR_STAT)
    begin
      rd_next[0] = readable_reg[sel_reg];
      rd_next[1] = sendable_reg[sel_reg];
      rd_next[2] = hold_reg[sel_reg];
      rd_next[upcc_pkg::STAT_CNT_POS +: 13] = cnt_reg[sel_reg];
    end
    else if (paddr == upcc_pkg::ADDR_SIZE)
    begin
      if (buf_pipe(sel_reg))
        rd_next[13:0] = cur.double_side_fifo ? {side_bytes(cur), 1'b0} : {1'b0, side_bytes(cur)}; // RULE_13
      else
        rd_next[13:0] = {1'b0, upcc_pkg::BLOCK_BYTES};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end
    else if (rd_take)
    begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
      err_reg <= !hit;
    end
  end

  // ----------------------------------------------------------------
  // Pipe configuration
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_reg <= upcc_pkg::SEL_RESET;
    else if (wr_take && paddr == upcc_pkg::ADDR_SEL && pwdata[3:0] <= 4'(upcc_pkg::NPIPE))
      sel_reg <= pwdata[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 1; i <= upcc_pkg::NPIPE; i++)
      begin
        cfg_reg[i] <= '0;
        cfg_reg[i].max_pkt <= upcc_pkg::MAXP_RESET;
        flush_reg[i] <= 1'b0;
      end
    end
    else if (wr_take && sel_reg != 4'h0) // RULE_01
    begin
      if (paddr == upcc_pkg::ADDR_CFG)
      begin
        cfg_reg[sel_reg].kind <= upcc_pkg::upcc_kind_t'(pwdata[upcc_pkg::CFG_KIND_POS +: 2]); // RULE_02
        cfg_reg[sel_reg].ready_on_read_option <= pwdata[upcc_pkg::CFG_ROR_POS];
        cfg_reg[sel_reg].double_side_fifo <= pwdata[upcc_pkg::CFG_DBL_POS];
        cfg_reg[sel_reg].continuous_mode <= pwdata[upcc_pkg::CFG_CONT_POS];
        cfg_reg[sel_reg].dir <= pwdata[upcc_pkg::CFG_DIR_POS];
      end
      if (paddr == upcc_pkg::ADDR_ALLOC)
        cfg_reg[sel_reg].fifo_block_count <= pwdata[upcc_pkg::ALLOC_BC_POS +: 5];
      if (paddr == upcc_pkg::ADDR_MAXP)
        cfg_reg[sel_reg].max_pkt <= pwdata[10:0];
      if (paddr == upcc_pkg::ADDR_CTRL)
      begin
        cfg_reg[sel_reg].accept <= pwdata[upcc_pkg::CTRL_MODE_POS] && (cur.kind != upcc_pkg::UPCC_KIND_NONE); // RULE_04
        cfg_reg[sel_reg].txn_target <= pwdata[upcc_pkg::CTRL_TXN_POS +: 8];
        flush_reg[sel_reg] <= pwdata[upcc_pkg::CTRL_FLUSH_POS];
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO state per pipe
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      readable_reg <= 10'h000;
      sendable_reg <= 10'h000;
      hold_reg <= 10'h000;
      event_reg <= 10'h000;
      for (int i = 1; i <= upcc_pkg::NPIPE; i++)
      begin
        cnt_reg[i] <= 13'h0000;
        pkts_reg[i] <= 8'h00;
      end
    end
    else
    begin
      event_reg <= 10'h000;
      for (int i = 1; i <= upcc_pkg::NPIPE; i++)
      begin
        logic [3:0] p;
        logic [12:0] sum;
        logic [7:0] np;
        logic ror;
        logic quiet_tx;
        p = 4'(i);
        sum = 13'h0000;
        np = 8'h00;
        ror = cfg_reg[i].ready_on_read_option && buf_pipe(p); // RULE_07
        quiet_tx = buf_pipe(p) && cfg_reg[i].dir && (cfg_reg[i].ready_on_read_option || cfg_reg[i].double_side_fifo);
        if (flush_reg[i])
        begin
          readable_reg[i] <= 1'b0;
          sendable_reg[i] <= 1'b0;
          hold_reg[i] <= 1'b0;
          cnt_reg[i] <= 13'h0000;
          pkts_reg[i] <= 8'h00;
        end
        else if (!cfg_reg[i].dir)
        begin
          if (pkt_for(rx_pkt, p) && cfg_reg[i].accept && !readable_reg[i] && !hold_reg[i])
          begin
            sum = cnt_reg[i] + {2'b00, rx_pkt.bytes};
            np = pkts_reg[i] + 8'h01;
            cnt_reg[i] <= sum;
            pkts_reg[i] <= np;
            if (!cont_on(cfg_reg[i], p) ||
                sum == side_bytes(cfg_reg[i]) || // RULE_18
                (rx_pkt.bytes != 11'h000 && rx_pkt.bytes < cfg_reg[i].max_pkt) || // RULE_19
                (rx_pkt.bytes == 11'h000 && cnt_reg[i] != 13'h0000) || // RULE_19
                (cfg_reg[i].txn_target != 8'h00 && np == cfg_reg[i].txn_target)) // RULE_20
            begin
              readable_reg[i] <= 1'b1; // RULE_16
              event_reg[i] <= !ror;
            end
          end
          if (wr_take && paddr == upcc_pkg::ADDR_CTRL && sel_reg == p && pwdata[upcc_pkg::CTRL_CLR_POS])
            hold_reg[i] <= 1'b0; // RULE_09
          if (pkt_for(cpu_rd_done, p) && readable_reg[i])
          begin
            readable_reg[i] <= 1'b0;
            cnt_reg[i] <= 13'h0000;
            pkts_reg[i] <= 8'h00;
            hold_reg[i] <= ror; // RULE_09
            event_reg[i] <= ror; // RULE_08
          end
        end
        else
        begin
          if (pkt_for(cpu_wr, p) && !sendable_reg[i])
          begin
            sum = cnt_reg[i] + {2'b00, cpu_wr.bytes};
            cnt_reg[i] <= sum;
            if (cont_on(cfg_reg[i], p))
            begin
              if (sum >= side_bytes(cfg_reg[i]) || cpu_commit || !dma_last_write_n) // RULE_21 RULE_22
                sendable_reg[i] <= 1'b1;
            end
            else if (sum >= {2'b00, cfg_reg[i].max_pkt} || cpu_commit) // RULE_17
              sendable_reg[i] <= 1'b1;
          end
          else if (cpu_commit && cpu_wr.pipe == p && !sendable_reg[i])
            sendable_reg[i] <= 1'b1; // RULE_17 RULE_21
          if (pkt_for(tx_sent, p) && sendable_reg[i])
          begin
            sendable_reg[i] <= 1'b0;
            cnt_reg[i] <= 13'h0000;
            event_reg[i] <= !quiet_tx; // RULE_10 RULE_14
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    traffic_enable = 10'h000;
    for (int i = 1; i <= upcc_pkg::NPIPE; i++)
      traffic_enable[i] = cfg_reg[i].accept && (cfg_reg[i].kind != upcc_pkg::UPCC_KIND_NONE); // RULE_04
  end

  assign fifo_readable = readable_reg;
  assign fifo_sendable = sendable_reg;
  assign fifo_ready_event = event_reg;
endmodule : upcc_pipe_config
`default_nettype wire

/* verification/upcc_props.sv */
`default_nettype none
module upcc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire upcc_pkg::upcc_pkt_t rx_pkt,
  input wire upcc_pkg::upcc_pkt_t tx_sent,
  input wire upcc_pkg::upcc_pkt_t cpu_wr,
  input wire logic cpu_commit,
  input wire logic dma_last_write_n,
  input wire upcc_pkg::upcc_pkt_t cpu_rd_done,
  input wire logic [9:0] traffic_enable,
  input wire logic [9:0] fifo_readable,
  input wire logic [9:0] fifo_sendable,
  input wire logic [9:0] fifo_ready_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Cause vectors and checks
  // ----------------------------------------
  logic [9:0] rx_hot;
  logic [9:0] rd_hot;
  logic [9:0] wr_hot;
  logic [9:0] tx_hot;
  logic [9:0] ev_src;
  logic bus_wr;
  assign rx_hot = rx_pkt.valid ? (10'h001 << rx_pkt.pipe) : 10'h000;
  assign rd_hot = cpu_rd_done.valid ? (10'h001 << cpu_rd_done.pipe) : 10'h000;
  assign wr_hot = cpu_wr.valid ? (10'h001 << cpu_wr.pipe) : 10'h000;
  assign tx_hot = tx_sent.valid ? (10'h001 << tx_sent.pipe) : 10'h000;
  assign ev_src = rx_hot | rd_hot | tx_hot;
  assign bus_wr = psel & penable & pwrite & pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_pipe_idle: assert property ((traffic_enable[0] | fifo_readable[0] | fifo_sendable[0]) == 1'b0)
    else $error("pipe zero shows activity");
  a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_enable_by_write: assert property ($changed(traffic_enable) |-> $past(bus_wr))
    else $error("traffic enable changed without a write");
  a_readable_rise: assert property ((fifo_readable & ~$past(fifo_readable) & ~$past(rx_hot)) == 10'h000)
    else $error("readable rose without a packet");
  a_readable_fall: assert property (((~fifo_readable & $past(fifo_readable) & ~$past(rd_hot)) == 10'h000)
    || $past(bus_wr, 2))
    else $error("readable fell without read done");
  a_sendable_rise: assert property (((fifo_sendable & ~$past(fifo_sendable) & ~$past(wr_hot)) == 10'h000)
    || $past(cpu_commit))
    else $error("sendable rose without a write");
  a_sendable_fall: assert property (((~fifo_sendable & $past(fifo_sendable) & ~$past(tx_hot)) == 10'h000)
    || $past(bus_wr, 2))
    else $error("sendable fell without a send");
  a_event_cause: assert property ((fifo_ready_event & ~$past(ev_src)) == 10'h000)
    else $error("ready event without a cause");
  c_event: cover property (|fifo_ready_event);
  c_sendable: cover property (|fifo_sendable);
  c_error: cover property (pslverr);
endmodule : upcc_props
bind upcc_pipe_config upcc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_pkt(rx_pkt), .tx_sent(tx_sent), .cpu_wr(cpu_wr), .cpu_commit(cpu_commit),
  .dma_last_write_n(dma_last_write_n), .cpu_rd_done(cpu_rd_done), .traffic_enable(traffic_enable),
  .fifo_readable(fifo_readable), .fifo_sendable(fifo_sendable), .fifo_ready_event(fifo_ready_event));
`default_nettype wire

/* verification/upcc_host_model.sv */
`default_nettype none
module upcc_host_model (
  input wire logic pclk,
  input wire logic [9:0] traffic_enable,
  output var upcc_pkg::upcc_pkt_t rx_pkt,
  output var upcc_pkg::upcc_pkt_t tx_sent
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Packet exchange, prompt or slow
  // ----------------------------------------
  initial
  begin
    rx_pkt = '0;
    tx_sent = '0;
  end
  task automatic xfer(input logic is_tx, input logic [3:0] p, input logic [10:0] n, input int slow);
    repeat (slow) @(posedge pclk);
    @(posedge pclk);
    if (traffic_enable[p] === 1'b1)
    begin
      if (is_tx)
        tx_sent <= {1'b1, p, n};
      else
        rx_pkt <= {1'b1, p, n};
    end
    @(posedge pclk);
    rx_pkt <= {1'b0, ~rx_pkt[14:0]};
    tx_sent <= {1'b0, ~tx_sent[14:0]};
    #1;
  endtask : xfer
endmodule : upcc_host_model
`default_nettype wire

/* verification/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] p; logic [1:0] k; logic d; logic [4:0] bc; logic [13:0] al; logic te;} upcc_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, cpu_commit, dma_last_write_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata_q;
  logic [9:0] traffic_enable, fifo_readable, fifo_sendable, fifo_ready_event;
  upcc_pkg::upcc_pkt_t rx_pkt, tx_sent, cpu_wr, cpu_rd_done;
  int miscompares = 0;
  int tests_run = 0;
  upcc_row_t rows [5] = '{'{4'h1, 2'h0, 1'b0, 5'h00, 14'h0040, 1'b0}, '{4'h1, 2'h1, 1'b1, 5'h01, 14'h0100, 1'b1},
    '{4'h3, 2'h1, 1'b0, 5'h04, 14'h0140, 1'b1}, '{4'h2, 2'h3, 1'b1, 5'h1F, 14'h1000, 1'b1},
    '{4'h6, 2'h2, 1'b0, 5'h03, 14'h0040, 1'b1}};
  upcc_pipe_config u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pkt(rx_pkt),
    .tx_sent(tx_sent), .cpu_wr(cpu_wr), .cpu_commit(cpu_commit), .dma_last_write_n(dma_last_write_n),
    .cpu_rd_done(cpu_rd_done), .traffic_enable(traffic_enable), .fifo_readable(fifo_readable),
    .fifo_sendable(fifo_sendable), .fifo_ready_event(fifo_ready_event));
  upcc_host_model u_host (.pclk(pclk), .traffic_enable(traffic_enable), .rx_pkt(rx_pkt), .tx_sent(tx_sent));
  // ----------------------------------------
  // Bus, pulse and compare tasks
  // ----------------------------------------
  always #5 pclk = ~pclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic drv(input logic rd, input logic [3:0] p, input logic [10:0] n, input logic c, input logic l);
    @(posedge pclk);
    if (rd)
      cpu_rd_done <= {1'b1, p, n};
    else
      cpu_wr <= {1'b1, p, n};
    cpu_commit <= c;
    dma_last_write_n <= l;
    @(posedge pclk);
    cpu_wr <= {1'b0, ~cpu_wr[14:0]};
    cpu_rd_done <= {1'b0, ~cpu_rd_done[14:0]};
    cpu_commit <= 1'b0;
    dma_last_write_n <= 1'b1;
    #1;
  endtask : drv
  function automatic logic [31:0] cfgw(input logic [1:0] k, input logic r, d, c, t);
    return (32'(k) << upcc_pkg::CFG_KIND_POS) | (32'(r) << upcc_pkg::CFG_ROR_POS) |
      (32'(d) << upcc_pkg::CFG_DBL_POS) | (32'(c) << upcc_pkg::CFG_CONT_POS) | (32'(t) << upcc_pkg::CFG_DIR_POS);
  endfunction : cfgw
  task automatic setp(input logic [3:0] p, input logic [31:0] cfg, input logic [4:0] bc);
    apb(1'b1, upcc_pkg::ADDR_SEL, 32'(p));
    apb(1'b1, upcc_pkg::ADDR_CTRL, 32'h0000_0002);
    apb(1'b1, upcc_pkg::ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, upcc_pkg::ADDR_CFG, cfg);
    apb(1'b1, upcc_pkg::ADDR_ALLOC, 32'(bc) << upcc_pkg::ALLOC_BC_POS);
    apb(1'b1, upcc_pkg::ADDR_CTRL, 32'h0000_0001);
  endtask : setp
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial
  begin
    #100000;
    miscompares++;
    end_of_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, cpu_commit} = 6'h00;
    {paddr, pwdata, dma_last_write_n} = {8'h00, 32'h0000_0000, 1'b1};
    {cpu_wr, cpu_rd_done} = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    chk("reset_outputs", 32'h0000_0000, {fifo_readable, fifo_sendable, fifo_ready_event, pready});
    presetn <= 1'b1;
    apb(1'b0, upcc_pkg::ADDR_SEL, 32'h0000_0000);
    chk("sel_reset", 32'(upcc_pkg::SEL_RESET), rdata_q);
    apb(1'b1, upcc_pkg::ADDR_CFG, 32'h0000_4000);
    apb(1'b1, upcc_pkg::ADDR_SEL, 32'h0000_0001);
    apb(1'b0, upcc_pkg::ADDR_CFG, 32'h0000_0000);
    chk("cfg_unselected", 32'h0000_0000, rdata_q);
    apb(1'b0, upcc_pkg::ADDR_MAXP, 32'h0000_0000);
    chk("maxp_reset", 32'(upcc_pkg::MAXP_RESET), rdata_q);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, 32'(err_q));
    $display("test reset done");
    foreach (rows[i])
    begin
      setp(rows[i].p, cfgw(rows[i].k, 1'b0, rows[i].d, 1'b0, 1'b0), rows[i].bc);
      apb(1'b0, upcc_pkg::ADDR_CFG, 32'h0000_0000);
      chk("cfg", cfgw(rows[i].k, 1'b0, rows[i].d, 1'b0, 1'b0), rdata_q);
      apb(1'b0, upcc_pkg::ADDR_SIZE, 32'h0000_0000);
      chk("alloc", 32'(rows[i].al), rdata_q);
      chk("enable", 32'(rows[i].te), 32'(traffic_enable[rows[i].p]));
    end
    $display("test table done");
    u_host.xfer(1'b0, 4'h1, 11'h040, 0);
    chk("rx_readable", 32'h0000_0003, {fifo_readable[1], fifo_ready_event[1]});
    drv(1'b1, 4'h1, 11'h040, 1'b0, 1'b1);
    chk("rx_drained", 32'h0000_0000, 32'(fifo_readable[1]));
    setp(4'h3, cfgw(2'h1, 1'b1, 1'b0, 1'b0, 1'b0), 5'h00);
    u_host.xfer(1'b0, 4'h3, 11'h040, 2);
    chk("ror_rx", 32'h0000_0002, {fifo_readable[3], fifo_ready_event[3]});
    drv(1'b1, 4'h3, 11'h040, 1'b0, 1'b1);
    chk("ror_read", 32'h0000_0001, {fifo_readable[3], fifo_ready_event[3]});
    u_host.xfer(1'b0, 4'h3, 11'h040, 0);
    chk("ror_held", 32'h0000_0000, 32'(fifo_readable[3]));
    apb(1'b1, upcc_pkg::ADDR_CTRL, 32'h0000_0005);
    u_host.xfer(1'b0, 4'h3, 11'h008, 0);
    chk("ror_clear", 32'h0000_0001, 32'(fifo_readable[3]));
    apb(1'b1, upcc_pkg::ADDR_CTRL, 32'h0000_0002);
    apb(1'b1, upcc_pkg::ADDR_CTRL, 32'h0000_0000);
    chk("flush", 32'h0000_0000, 32'(fifo_readable[3]));
    setp(4'h3, cfgw(2'h1, 1'b0, 1'b0, 1'b1, 1'b0), 5'h01);
    u_host.xfer(1'b0, 4'h3, 11'h040, 0);
    chk("cont_rx_part", 32'h0000_0000, 32'(fifo_readable[3]));
    u_host.xfer(1'b0, 4'h3, 11'h040, 0);
    chk("cont_rx_side", 32'h0000_0003, {fifo_readable[3], fifo_ready_event[3]});
    drv(1'b1, 4'h3, 11'h080, 1'b0, 1'b1);
    u_host.xfer(1'b0, 4'h3, 11'h040, 0);
    u_host.xfer(1'b0, 4'h3, 11'h000, 0);
    chk("cont_rx_zlp", 32'h0000_0001, 32'(fifo_readable[3]));
    drv(1'b1, 4'h3, 11'h040, 1'b0, 1'b1);
    apb(1'b1, upcc_pkg::ADDR_CTRL, 32'h0000_0101);
    u_host.xfer(1'b0, 4'h3, 11'h040, 0);
    chk("cont_rx_txn", 32'h0000_0001, 32'(fifo_readable[3]));
    $display("test receive done");
    setp(4'h4, cfgw(2'h1, 1'b0, 1'b1, 1'b0, 1'b1), 5'h00);
    drv(1'b0, 4'h4, 11'h020, 1'b0, 1'b1);
    chk("tx_half", 32'h0000_0000, 32'(fifo_sendable[4]));
    drv(1'b0, 4'h4, 11'h020, 1'b0, 1'b1);
    chk("tx_full", 32'h0000_0001, 32'(fifo_sendable[4]));
    u_host.xfer(1'b1, 4'h4, 11'h040, 3);
    chk("dbl_tx_sent", 32'h0000_0000, {fifo_sendable[4], fifo_ready_event[4]});
    drv(1'b0, 4'h4, 11'h00A, 1'b1, 1'b1);
    chk("tx_commit", 32'h0000_0001, 32'(fifo_sendable[4]));
    setp(4'h5, cfgw(2'h1, 1'b0, 1'b0, 1'b1, 1'b1), 5'h00);
    drv(1'b0, 4'h5, 11'h014, 1'b0, 1'b0);
    chk("cont_last", 32'h0000_0001, 32'(fifo_sendable[5]));
    u_host.xfer(1'b1, 4'h5, 11'h014, 0);
    chk("cont_sent", 32'h0000_0001, {fifo_sendable[5], fifo_ready_event[5]});
    drv(1'b0, 4'h5, 11'h028, 1'b0, 1'b1);
    chk("cont_part", 32'h0000_0000, 32'(fifo_sendable[5]));
    drv(1'b0, 4'h5, 11'h018, 1'b0, 1'b1);
    chk("cont_fill", 32'h0000_0001, 32'(fifo_sendable[5]));
    $display("test transmit done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
